// file: hdl/hp_pkg.sv
/*
 * Constants and carrier types for the two-channel serial host port.
 * Assumes one 100 MHz clock, synchronous active-low reset, and pins sampled
 * as synchronous inputs. The channel protocol engines sit outside this block.
 */
// Contract
// - Mode 0: channel-A pin is ready line
// - Modes 1, 2: channel-A pin is receive DMA
// - Priority out low: input low, not in service
// - Mode 2: priority out is channel-B transmit DMA
// - Open-collector interrupt while interrupt is pending
// - Acknowledge lets device give vector; idle high
// - Channel line low selects A, high B
// - Select line low data, high command/status
// - Strobes honoured only under chip select; acknowledge is taken without it
// - Read returns byte, write accepts byte
// - Reset idles channels, serial outputs high
// - Reset drives send-request, terminal-ready high
// - Reset clears both register pointers
// - Eight writable command registers per channel
// - Two status registers for A, three for B
package hp_pkg;

   localparam int NUM_CHAN = 2;
   localparam int NUM_WR   = 8;
   localparam int PTR_W    = 3;
   localparam int BYTE_W   = 8;

   // Interface modes.
   localparam logic [1:0] MODE_READY   = 2'h0;
   localparam logic [1:0] MODE_DMA_RX  = 2'h1;
   localparam logic [1:0] MODE_DMA_ALL = 2'h2;

   // Address decode levels.
   localparam logic CHAN_A   = 1'b0;
   localparam logic SEL_DATA = 1'b0;

   // Command register indices.
   localparam logic [PTR_W-1:0] REG_PTR    = 3'h0;
   localparam logic [PTR_W-1:0] REG_VECTOR = 3'h2;
   localparam logic [PTR_W-1:0] REG_RX_CTL = 3'h3;
   localparam logic [PTR_W-1:0] REG_TX_CTL = 3'h5;

   // Highest readable status index per channel.
   localparam logic [PTR_W-1:0] STAT_LAST_A = 3'h1;
   localparam logic [PTR_W-1:0] STAT_LAST_B = 3'h2;

   // Field positions.
   localparam int PTR_LO    = 0;
   localparam int CMD_LO    = 3;
   localparam int RX_EN_BIT = 0;
   localparam int RTS_BIT   = 1;
   localparam int TX_EN_BIT = 3;
   localparam int BREAK_BIT = 4;
   localparam int DTR_BIT   = 7;

   // Command code in the pointer register that ends interrupt service.
   localparam logic [2:0] CMD_END_INT = 3'h7;

   localparam logic [BYTE_W-1:0] RESET_BYTE = 8'h00;

   typedef logic [NUM_WR-1:0][BYTE_W-1:0] hp_regs_t;

   // Processor bus pins as seen by the block.
   typedef struct packed {
      logic              cs_n;
      logic              rd_n;
      logic              wr_n;
      logic              channel_select_line;
      logic              data_command_select;
      logic [BYTE_W-1:0] din;
   } hp_bus_t;

   // Per-channel signals coming from the protocol engine.
   typedef struct packed {
      logic              rx_avail;
      logic              tx_empty;
      logic              irq;
      logic              txd;
      logic [BYTE_W-1:0] rx_data;
      logic [BYTE_W-1:0] stat0;
      logic [BYTE_W-1:0] stat1;
      logic [BYTE_W-1:0] stat2;
   } hp_chan_in_t;

   // Per-channel signals going to the engine and the line.
   typedef struct packed {
      logic              idle;
      logic              txd;
      logic              rts_n;
      logic              dtr_n;
      logic              tx_load;
      logic              rx_take;
      logic [BYTE_W-1:0] tx_data;
   } hp_chan_out_t;

endpackage

// file: hdl/hp_strobe.sv
/*
 * Start-of-strobe detector for the read, write and acknowledge pins.
 * Assumes the pins are synchronous to clock; each pulse lasts one cycle.
 */
`timescale 1ns/1ns
module hp_strobe (
   input  wire logic clock,
   input  wire logic rst_n,
   input  wire logic cs_n,
   input  wire logic rd_n,
   input  wire logic wr_n,
   input  wire logic ack_n,
   output logic      rd_pulse,
   output logic      wr_pulse,
   output logic      ack_pulse
);
   typedef struct packed {
      logic rd_q;
      logic wr_q;
      logic ack_q;
      logic rd_p;
      logic wr_p;
      logic ack_p;
   } hp_strobe_state_t;

   hp_strobe_state_t state;
   hp_strobe_state_t next_state;

   // A falling read or write strobe counts only while chip select is low; acknowledge is not gated by chip select.
   always_comb begin
      next_state       = state;
      next_state.rd_q  = rd_n;
      next_state.wr_q  = wr_n;
      next_state.ack_q = ack_n;
      next_state.rd_p  = state.rd_q & ~rd_n & ~cs_n;
      next_state.wr_p  = state.wr_q & ~wr_n & ~cs_n;
      next_state.ack_p = state.ack_q & ~ack_n;
   end

   // Idle strobes are high after reset so no false edge is seen.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state <= '{rd_q: 1'b1, wr_q: 1'b1, ack_q: 1'b1, default: 1'b0};
      end else begin
         state <= next_state;
      end
   end

   assign rd_pulse  = state.rd_p;
   assign wr_pulse  = state.wr_p;
   assign ack_pulse = state.ack_p;
endmodule

// file: hdl/hp_cmd_bank.sv
/*
 * Command register bank of one channel: eight writable bytes and the pointer.
 * Assumes access pulses last one cycle and only one arrives at a time.
 */
`timescale 1ns/1ns
module hp_cmd_bank (
   input  wire logic                      clock,
   input  wire logic                      rst_n,
   input  wire logic                      cmd_write,
   input  wire logic                      cmd_read,
   input  wire logic [hp_pkg::BYTE_W-1:0] wdata,
   output hp_pkg::hp_regs_t               regs,
   output logic [hp_pkg::PTR_W-1:0]       ptr
);
   typedef struct packed {
      hp_pkg::hp_regs_t           regs;
      logic [hp_pkg::PTR_W-1:0]   ptr;
   } hp_bank_state_t;

   hp_bank_state_t state;
   hp_bank_state_t next_state;

   // Register zero loads the pointer; any other access consumes it.
   always_comb begin
      next_state = state;
      if (cmd_write) begin
         next_state.regs[state.ptr] = wdata;
         if (state.ptr == hp_pkg::REG_PTR) begin
            next_state.ptr = wdata[hp_pkg::PTR_LO +: hp_pkg::PTR_W];
         end else begin
            next_state.ptr = hp_pkg::REG_PTR;
         end
      end else if (cmd_read) begin
         next_state.ptr = hp_pkg::REG_PTR;
      end
   end

   // Reset clears every register and the pointer.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state.regs <= '0;
         state.ptr  <= hp_pkg::REG_PTR;
      end else begin
         state <= next_state;
      end
   end

   assign regs = state.regs;
   assign ptr  = state.ptr;
endmodule

// file: hdl/hp_host_port.sv
/*
 * Processor-side port of a two-channel serial controller: address decode,
 * read and write strobes, register pointer, ready and DMA request pins,
 * priority chain, interrupt and vector, and line levels after reset.
 * Assumes all pins are synchronous to clock and that the serial engines
 * supply buffer state, status bytes and their own interrupt requests.
 */
`timescale 1ns/1ns
module hp_host_port (
   input  wire logic                       clock,
   input  wire logic                       rst_n,
   input  wire logic [1:0]                 interface_mode,
   input  wire hp_pkg::hp_bus_t            bus,
   input  wire logic                       interrupt_acknowledge_in,
   input  wire hp_pkg::hp_chan_in_t        chan_a_in,
   input  wire hp_pkg::hp_chan_in_t        chan_b_in,
   input  wire logic                       prio_in_pin,
   output logic [hp_pkg::BYTE_W-1:0]       dout,
   output logic                            dout_oe_n,
   output logic                            ready_a_or_rx_dma,
   output logic                            ready_b_or_tx_dma,
   output logic                            prio_out_n_or_tx_dma,
   output logic                            prio_in_out,
   output logic                            prio_in_oe_n,
   output logic                            int_out,
   output logic                            int_oe_n,
   output hp_pkg::hp_chan_out_t            chan_a_out,
   output hp_pkg::hp_chan_out_t            chan_b_out
);
   typedef struct packed {
      logic [hp_pkg::BYTE_W-1:0] dout;
      logic                      driving;
      logic                      ready_a;
      logic                      ready_b;
      logic                      prio_out;
      logic                      prio_in_out;
      logic                      prio_in_oe_n;
      logic                      int_oe_n;
      logic                      in_service;
      hp_pkg::hp_chan_out_t      ch_a;
      hp_pkg::hp_chan_out_t      ch_b;
   } hp_port_state_t;

   hp_port_state_t state;
   hp_port_state_t next_state;

   logic                      rd_pulse;
   logic                      wr_pulse;
   logic                      ack_pulse;
   hp_pkg::hp_regs_t          regs [hp_pkg::NUM_CHAN];
   logic [hp_pkg::PTR_W-1:0]  ptr [hp_pkg::NUM_CHAN];
   hp_pkg::hp_chan_in_t       cin [hp_pkg::NUM_CHAN];
   logic [hp_pkg::NUM_CHAN-1:0] cmd_wr;
   logic [hp_pkg::NUM_CHAN-1:0] cmd_rd;

   // Strobe edges; read and write are qualified by chip select, acknowledge is not.
   hp_strobe u_strobe (
      .clock     (clock),
      .rst_n     (rst_n),
      .cs_n      (bus.cs_n),
      .rd_n      (bus.rd_n),
      .wr_n      (bus.wr_n),
      .ack_n     (interrupt_acknowledge_in),
      .rd_pulse  (rd_pulse),
      .wr_pulse  (wr_pulse),
      .ack_pulse (ack_pulse)
   );

   assign cin[0] = chan_a_in;
   assign cin[1] = chan_b_in;

   // One command bank per channel, chosen by the channel line.
   genvar g;
   generate
      for (g = 0; g < hp_pkg::NUM_CHAN; g++) begin : g_bank
         assign cmd_wr[g] = wr_pulse & (bus.data_command_select != hp_pkg::SEL_DATA)
                            & (bus.channel_select_line == 1'(g));
         assign cmd_rd[g] = rd_pulse & (bus.data_command_select != hp_pkg::SEL_DATA)
                            & (bus.channel_select_line == 1'(g));
         hp_cmd_bank u_bank (
            .clock     (clock),
            .rst_n     (rst_n),
            .cmd_write (cmd_wr[g]),
            .cmd_read  (cmd_rd[g]),
            .wdata     (bus.din),
            .regs      (regs[g]),
            .ptr       (ptr[g])
         );
      end
   endgenerate

   // Picks the status byte at the pointer; unbuilt indices read zero.
   function automatic logic [hp_pkg::BYTE_W-1:0] status_byte(
      input hp_pkg::hp_chan_in_t      ci,
      input logic [hp_pkg::PTR_W-1:0] idx,
      input logic [hp_pkg::PTR_W-1:0] last);
      logic [hp_pkg::BYTE_W-1:0] b;
      b = hp_pkg::RESET_BYTE;
      if (idx > last) begin
         b = hp_pkg::RESET_BYTE;
      end else if (idx == 3'h0) begin
         b = ci.stat0;
      end else if (idx == 3'h1) begin
         b = ci.stat1;
      end else begin
         b = ci.stat2;
      end
      return b;
   endfunction

   // Derives line outputs of one channel from its command bytes.
   function automatic hp_pkg::hp_chan_out_t line_out(
      input hp_pkg::hp_regs_t    r,
      input hp_pkg::hp_chan_in_t ci);
      hp_pkg::hp_chan_out_t o;
      o         = '0;
      o.idle    = ~(r[hp_pkg::REG_RX_CTL][hp_pkg::RX_EN_BIT]
                    | r[hp_pkg::REG_TX_CTL][hp_pkg::TX_EN_BIT]);
      o.txd     = o.idle ? 1'b1
                  : (~r[hp_pkg::REG_TX_CTL][hp_pkg::BREAK_BIT] & ci.txd);
      o.rts_n   = ~r[hp_pkg::REG_TX_CTL][hp_pkg::RTS_BIT];
      o.dtr_n   = ~r[hp_pkg::REG_TX_CTL][hp_pkg::DTR_BIT];
      return o;
   endfunction

   logic                       sel_b;
   logic                       sel_cmd;
   logic                       any_irq;
   logic                       ready_mode;
   logic                       dma_all;
   hp_pkg::hp_chan_in_t        ci_sel;
   logic [hp_pkg::PTR_W-1:0]   ptr_sel;
   logic [hp_pkg::PTR_W-1:0]   last_sel;

   always_comb begin
      sel_b      = (bus.channel_select_line != hp_pkg::CHAN_A);
      sel_cmd    = (bus.data_command_select != hp_pkg::SEL_DATA);
      ci_sel     = sel_b ? cin[1] : cin[0];
      ptr_sel    = sel_b ? ptr[1] : ptr[0];
      last_sel   = sel_b ? hp_pkg::STAT_LAST_B : hp_pkg::STAT_LAST_A;
      any_irq    = chan_a_in.irq | chan_b_in.irq;
      ready_mode = (interface_mode == hp_pkg::MODE_READY);
      dma_all    = (interface_mode == hp_pkg::MODE_DMA_ALL);
   end

   // Next state of the port.
   always_comb begin
      next_state              = state;
      next_state.ch_a         = line_out(regs[0], chan_a_in);
      next_state.ch_b         = line_out(regs[1], chan_b_in);
      next_state.ch_a.tx_data = state.ch_a.tx_data;
      next_state.ch_b.tx_data = state.ch_b.tx_data;

      // End-of-interrupt command to channel A register zero; an acknowledge
      // in the same cycle is handled below and wins, so no request is lost.
      if (cmd_wr[0] && ptr[0] == hp_pkg::REG_PTR
          && bus.din[hp_pkg::CMD_LO +: 3] == hp_pkg::CMD_END_INT) begin
         next_state.in_service = 1'b0;
      end

      // Read strobe: latch the byte and drive the bus until the strobe ends.
      if (rd_pulse) begin
         next_state.driving = 1'b1;
         if (sel_cmd) begin
            next_state.dout = status_byte(ci_sel, ptr_sel, last_sel);
         end else begin
            next_state.dout = ci_sel.rx_data;
            next_state.ch_a.rx_take = ~sel_b;
            next_state.ch_b.rx_take = sel_b;
         end
      end else if (ack_pulse && any_irq && !state.int_oe_n) begin
         next_state.driving    = 1'b1;
         next_state.dout       = regs[1][hp_pkg::REG_VECTOR];
         next_state.in_service = 1'b1;
      end else if ((bus.rd_n | bus.cs_n) & interrupt_acknowledge_in) begin
         next_state.driving = 1'b0;
      end

      // Write strobe on the data path hands a byte to the engine.
      if (wr_pulse && !sel_cmd) begin
         if (sel_b) begin
            next_state.ch_b.tx_data = bus.din;
            next_state.ch_b.tx_load = 1'b1;
         end else begin
            next_state.ch_a.tx_data = bus.din;
            next_state.ch_a.tx_load = 1'b1;
         end
      end

      // Channel-A pin: ready in mode 0, receive DMA request otherwise.
      if (ready_mode) begin
         next_state.ready_a = ~(~bus.cs_n & ~sel_b & ~sel_cmd
                                & ((~bus.rd_n & ~chan_a_in.rx_avail)
                                   | (~bus.wr_n & ~chan_a_in.tx_empty)));
         next_state.ready_b = ~(~bus.cs_n & sel_b & ~sel_cmd
                                & ((~bus.rd_n & ~chan_b_in.rx_avail)
                                   | (~bus.wr_n & ~chan_b_in.tx_empty)));
      end else begin
         next_state.ready_a = chan_a_in.rx_avail;
         next_state.ready_b = chan_a_in.tx_empty;
      end

      // Priority chain in modes 0 and 1, channel-B DMA in mode 2.
      if (dma_all) begin
         next_state.prio_out     = chan_b_in.tx_empty;
         next_state.prio_in_out  = chan_b_in.rx_avail;
         next_state.prio_in_oe_n = 1'b0;
      end else begin
         next_state.prio_out     = prio_in_pin | state.in_service;
         next_state.prio_in_out  = 1'b1;
         next_state.prio_in_oe_n = 1'b1;
      end

      // Open-collector interrupt pulls low while a request waits.
      next_state.int_oe_n = ~(any_irq & ~state.in_service);
   end

   // Reset idles both channels and raises line and modem outputs.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         state              <= '0;
         state.ready_a      <= 1'b1;
         state.ready_b      <= 1'b1;
         state.prio_out     <= 1'b1;
         state.prio_in_out  <= 1'b1;
         state.prio_in_oe_n <= 1'b1;
         state.int_oe_n     <= 1'b1;
         state.ch_a         <= '{idle: 1'b1, txd: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                                default: '0};
         state.ch_b         <= '{idle: 1'b1, txd: 1'b1, rts_n: 1'b1, dtr_n: 1'b1,
                                default: '0};
      end else begin
         state <= next_state;
      end
   end

   // Every output except int_out, which is tied low, is taken straight from the state register.
   assign dout                 = state.dout;
   assign dout_oe_n            = ~state.driving;
   assign ready_a_or_rx_dma    = state.ready_a;
   assign ready_b_or_tx_dma    = state.ready_b;
   assign prio_out_n_or_tx_dma = state.prio_out;
   assign prio_in_out          = state.prio_in_out;
   assign prio_in_oe_n         = state.prio_in_oe_n;
   assign int_out              = 1'b0;
   assign int_oe_n             = state.int_oe_n;
   assign chan_a_out           = state.ch_a;
   assign chan_b_out           = state.ch_b;
endmodule

// file: tb/hp_host_port_assertions.sv
/* Checker for the host port pins.
   Bound into every hp_host_port; one clock, synchronous reset. */
`timescale 1ns/1ns
module hp_host_port_chk (
   input wire logic                       clock,
   input wire logic                       rst_n,
   input wire logic [1:0]                 interface_mode,
   input wire hp_pkg::hp_bus_t            bus,
   input wire logic                       interrupt_acknowledge_in,
   input wire hp_pkg::hp_chan_in_t        chan_a_in,
   input wire hp_pkg::hp_chan_in_t        chan_b_in,
   input wire logic                       prio_in_pin,
   input wire logic [hp_pkg::BYTE_W-1:0]  dout,
   input wire logic                       dout_oe_n,
   input wire logic                       ready_a_or_rx_dma,
   input wire logic                       ready_b_or_tx_dma,
   input wire logic                       prio_out_n_or_tx_dma,
   input wire logic                       prio_in_out,
   input wire logic                       prio_in_oe_n,
   input wire logic                       int_out,
   input wire logic                       int_oe_n,
   input wire hp_pkg::hp_chan_out_t       chan_a_out,
   input wire hp_pkg::hp_chan_out_t       chan_b_out
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   // A selected data write to channel B, as the bus shows it.
   wire logic wr_b = !bus.cs_n && !bus.wr_n && bus.channel_select_line
                     && bus.data_command_select == hp_pkg::SEL_DATA;
   // Reset must leave both lines marking and the modem outputs high.
   chk_reset_lines: assert property (disable iff (1'b0)
      !rst_n |=> chan_a_out.idle && chan_a_out.txd && chan_a_out.rts_n && chan_a_out.dtr_n
      && chan_b_out.idle && chan_b_out.txd && chan_b_out.rts_n && chan_b_out.dtr_n)
      else $error("line levels wrong under reset");
   chk_dma_pin_dir: assert property ($past(rst_n, 2) |->
      prio_in_oe_n == ($past(interface_mode) != hp_pkg::MODE_DMA_ALL))
      else $error("priority input pin direction wrong for mode");
   chk_prio_chain: assert property ($past(rst_n, 2)
      && $past(interface_mode) != hp_pkg::MODE_DMA_ALL && !prio_out_n_or_tx_dma
      |-> !$past(prio_in_pin)) else $error("priority out low with chain busy");
   chk_int_cause: assert property (!int_oe_n |->
      $past(chan_a_in.irq || chan_b_in.irq)) else $error("interrupt without request");
   chk_read_answer: assert property (!bus.cs_n && !bus.rd_n && $past(bus.rd_n)
      |-> ##[1:3] !dout_oe_n) else $error("read not answered");
   chk_cs_gate: assert property ((bus.cs_n && interrupt_acknowledge_in)[*4]
      |-> dout_oe_n) else $error("data bus driven while unselected");
   chk_write_load: assert property (wr_b && $past(bus.wr_n)
      |-> ##[1:3] chan_b_out.tx_load) else $error("channel B write not loaded");
   chk_load_pulse: assert property (chan_a_out.tx_load |=> !chan_a_out.tx_load)
      else $error("load pulse longer than one cycle");
   chk_load_cause: assert property (chan_b_out.tx_load |-> $past(wr_b, 2))
      else $error("channel B load without data write");
endmodule
bind hp_host_port hp_host_port_chk hp_host_port_chk_i (.clock, .rst_n, .interface_mode,
   .bus, .interrupt_acknowledge_in, .chan_a_in, .chan_b_in, .prio_in_pin, .dout,
   .dout_oe_n, .ready_a_or_rx_dma, .ready_b_or_tx_dma, .prio_out_n_or_tx_dma,
   .prio_in_out, .prio_in_oe_n, .int_out, .int_oe_n, .chan_a_out, .chan_b_out);

// file: tb/hp_far_side.sv
/* Far-side model: the two serial engines and the upstream priority chain.
   Assumes the bench steers request levels; bytes are fixed per channel. */
`timescale 1ns/1ns
module hp_far_side (
   input  wire logic           clock,
   input  wire logic           irq_a,
   input  wire logic           irq_b,
   input  wire logic           have_rx,
   input  wire logic           tx_room,
   input  wire logic           chain_free,
   input  wire logic           prio_in_out,
   input  wire logic           prio_in_oe_n,
   output hp_pkg::hp_chan_in_t chan_a_in,
   output hp_pkg::hp_chan_in_t chan_b_in,
   output logic                prio_in_pin
);
   // Engine state changes just after the edge; A idles its line low on purpose.
   always_ff @(posedge clock) begin
      chan_a_in <= '{have_rx, tx_room, irq_a, 1'b0, 8'hD0, 8'hA0, 8'hA1, 8'hA2};
      chan_b_in <= '{have_rx, tx_room, irq_b, 1'b1, 8'hD1, 8'hB0, 8'hB1, 8'hB2};
   end
   // Upstream pulls low only while no higher device is served, else the pull-up wins.
   assign prio_in_pin = !prio_in_oe_n ? prio_in_out : !chain_free;
endmodule

// file: tb/tb_hp_host_port.sv
/* Bench for the host port: far-side model, pin tasks, one task per scenario.
   Assumes the checker is bound in by its own file. */
`timescale 1ns/1ns
module tb_hp_host_port;
   logic                 clock = 1'b0;
   logic                 rst_n = 1'b0;
   logic [1:0]           interface_mode = 2'h0;
   hp_pkg::hp_bus_t      bus = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 8'h00};
   logic                 interrupt_acknowledge_in = 1'b1;
   logic                 irq_a = 1'b0, irq_b = 1'b0, chain_free = 1'b1;
   logic                 have_rx = 1'b1, tx_room = 1'b1;
   hp_pkg::hp_chan_in_t  chan_a_in, chan_b_in;
   hp_pkg::hp_chan_out_t chan_a_out, chan_b_out;
   logic [7:0]           dout, seen, sp;
   logic                 prio_in_pin, dout_oe_n, ready_a_or_rx_dma, ready_b_or_tx_dma;
   logic                 prio_out_n_or_tx_dma, prio_in_out, prio_in_oe_n, int_out, int_oe_n;
   int                   errors = 0, compares = 0, npl = 0, p;
   wire logic [7:0]      pins = {1'b0, ready_a_or_rx_dma, ready_b_or_tx_dma,
      prio_out_n_or_tx_dma, prio_in_oe_n, int_oe_n, dout_oe_n, int_out};
   wire logic [7:0]      lines = {chan_a_out.idle, chan_a_out.txd, chan_a_out.rts_n,
      chan_a_out.dtr_n, chan_b_out.idle, chan_b_out.txd, chan_b_out.rts_n, chan_b_out.dtr_n};

   hp_far_side hp_far_side_i (.clock, .irq_a, .irq_b, .have_rx, .tx_room, .chain_free,
      .prio_in_out, .prio_in_oe_n, .chan_a_in, .chan_b_in, .prio_in_pin);
   hp_host_port hp_host_port_i (.clock, .rst_n, .interface_mode, .bus,
      .interrupt_acknowledge_in, .chan_a_in, .chan_b_in, .prio_in_pin, .dout, .dout_oe_n,
      .ready_a_or_rx_dma, .ready_b_or_tx_dma, .prio_out_n_or_tx_dma, .prio_in_out,
      .prio_in_oe_n, .int_out, .int_oe_n, .chan_a_out, .chan_b_out);

   // The clock toggles every half period of 5 ns.
   always #5 clock = ~clock;
   // Engine pulses are tallied with weights: A load 1, B load 4, A take 16, B take 64.
   always @(posedge clock) npl <= npl + chan_a_out.tx_load + 4 * chan_b_out.tx_load
      + 16 * chan_a_out.rx_take + 64 * chan_b_out.rx_take;

   task automatic check(input string what, input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic results();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // One strobe held over five edges; read byte and pins are captured before release.
   task automatic acc(input logic rd, ch, cmd, input logic [7:0] d, input logic cs = 1'b1);
      @(posedge clock);
      bus <= '{!cs, !rd, rd, ch, cmd, d};
      hold(4);
      seen = dout;
      sp = pins;
      @(posedge clock);
      bus <= '{1'b1, 1'b1, 1'b1, ch, cmd, d};
      #1;
   endtask
   task automatic do_reset();
      @(posedge clock);
      rst_n <= 1'b0;
      hold(5);
      @(posedge clock);
      rst_n <= 1'b1;
      hold(2);
   endtask

   task automatic t_status();
      check("lines after reset", lines, 8'hFF);
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      check("status b0 after reset", seen, 8'hB0);
      for (int i = 0; i < 6; i++) begin
         acc(1'b0, i[0], 1'b1, 8'(i / 2));
         acc(1'b1, i[0], 1'b1, 8'h00);
         check("status byte", seen, (i == 4) ? 8'h00 : {i[0] ? 4'hB : 4'hA, 4'(i / 2)});
      end
      acc(1'b1, 1'b1, 1'b1, 8'h00);
      check("pointer back to zero", seen, 8'hB0);
      $display("t_status done");
   endtask
   task automatic t_data();
      p = npl;
      acc(1'b0, 1'b0, 1'b0, 8'h5A);
      acc(1'b0, 1'b1, 1'b0, 8'hC3);
      check("tx byte a", chan_a_out.tx_data, 8'h5A);
      check("tx byte b", chan_b_out.tx_data, 8'hC3);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      check("rx byte a", seen, 8'hD0);
      acc(1'b1, 1'b1, 1'b0, 8'h00);
      check("rx byte b", seen, 8'hD1);
      check("pulse tally", 8'(npl - p), 8'h55);
      $display("t_data done");
   endtask
   task automatic t_refuse();
      p = npl;
      acc(1'b1, 1'b0, 1'b1, 8'h00, 1'b0);
      check("bus idle unselected", sp, 8'h6E);
      acc(1'b0, 1'b1, 1'b0, 8'h11, 1'b0);
      acc(1'b0, 1'b0, 1'b1, 8'h01, 1'b0);
      check("tx byte kept", chan_b_out.tx_data, 8'hC3);
      check("no pulses", 8'(npl - p), 8'h00);
      acc(1'b1, 1'b0, 1'b1, 8'h00);
      check("pointer untouched", seen, 8'hA0);
      $display("t_refuse done");
   endtask
   task automatic t_lines();
      acc(1'b0, 1'b0, 1'b1, 8'h05);
      acc(1'b0, 1'b0, 1'b1, 8'h8A);
      acc(1'b0, 1'b1, 1'b1, 8'h05);
      acc(1'b0, 1'b1, 1'b1, 8'h18);
      check("line levels", lines, 8'h03);
      acc(1'b0, 1'b0, 1'b1, 8'h07);
      acc(1'b0, 1'b0, 1'b1, 8'hFF);
      acc(1'b0, 1'b0, 1'b1, 8'h01);
      do_reset();
      check("lines after reset", lines, 8'hFF);
      acc(1'b1, 1'b0, 1'b1, 8'h00);
      check("pointer cleared", seen, 8'hA0);
      $display("t_lines done");
   endtask
   task automatic t_int();
      acc(1'b0, 1'b1, 1'b1, 8'h02);
      acc(1'b0, 1'b1, 1'b1, 8'h7C);
      @(posedge clock);
      irq_a <= 1'b1;
      hold(3);
      check("request with chain free", pins, 8'h6A);
      @(posedge clock);
      chain_free <= 1'b0;
      hold(3);
      check("chain blocked", pins, 8'h7A);
      @(posedge clock);
      chain_free <= 1'b1;
      interrupt_acknowledge_in <= 1'b0;
      hold(4);
      check("vector byte", dout, 8'h7C);
      check("in service", pins, 8'h7C);
      @(posedge clock);
      interrupt_acknowledge_in <= 1'b1;
      irq_a <= 1'b0;
      acc(1'b0, 1'b0, 1'b1, 8'h38);
      @(posedge clock);
      irq_b <= 1'b1;
      hold(3);
      check("service ended", pins, 8'h6A);
      @(posedge clock);
      irq_b <= 1'b0;
      hold(2);
      $display("t_int done");
   endtask
   task automatic t_modes();
      @(posedge clock);
      interface_mode <= 2'h1;
      tx_room <= 1'b0;
      hold(3);
      check("mode 1 rx request", pins, 8'h4E);
      @(posedge clock);
      have_rx <= 1'b0;
      tx_room <= 1'b1;
      hold(3);
      check("mode 1 tx request", pins, 8'h2E);
      @(posedge clock);
      interface_mode <= 2'h2;
      hold(3);
      check("mode 2 pins", pins, 8'h36);
      check("mode 2 rx b", 8'(prio_in_out), 8'h00);
      @(posedge clock);
      have_rx <= 1'b1;
      tx_room <= 1'b0;
      hold(3);
      check("mode 2 pins swapped", pins, 8'h46);
      check("mode 2 rx b set", 8'(prio_in_out), 8'h01);
      @(posedge clock);
      interface_mode <= 2'h0;
      have_rx <= 1'b0;
      tx_room <= 1'b1;
      hold(1);
      acc(1'b1, 1'b0, 1'b0, 8'h00);
      check("ready held low", sp, 8'h2C);
      @(posedge clock);
      have_rx <= 1'b1;
      hold(3);
      check("ready restored", pins, 8'h6E);
      $display("t_modes done");
   endtask

   // Main sequence.
   initial begin
      do_reset();
      t_status();
      t_data();
      t_refuse();
      t_lines();
      t_int();
      t_modes();
      results();
   end
   // Watchdog: the tests need well under 2000 cycles.
   initial begin
      repeat (5000) @(posedge clock);
      errors++;
      $display("watchdog expired");
      results();
   end
endmodule
